// *** ebi_core.sv ***
// External bus interface: address, data lanes, area selects and strobes.
// Assumes requests and pins are synchronous to clk_sys.
// Function
// R1 - Width strap low gives 16-bit bus, high 8-bit
// R2 - Board ties width strap low in single-chip
// R3 - Mode strap picks single-chip or microprocessor mode
// R4 - Separate bus: low lane always, high if 16-bit
// R5 - Twenty address outputs, bits 0 to 19
// R6 - 8-bit multiplexed: address 0-7 then data 0-7
// R7 - 16-bit multiplexed: address 1-8 then data 0-7
// R8 - Four area selects, one per external area
// R9 - Lane strobes: low even write, high odd write
// R10 - Read data sampled while read strobe low
// R11 - Lane strobes switchable to write plus lane enable
// R12 - Software selects single strobe style on 8-bit bus
// R13 - Address latch strobe drives out for capture
// R14 - Wait input low stretches the bus cycle
// R15 - Hold acknowledge low while in hold state
// R16 - Bus request unused, pulled high by system
// R17 - Active reset forces the interface into reset
// R18 - Latch strobe in address phase, address removed
// R19 - Wait sampled each clock, end after high
module ebi_core
  import ebi_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  processor_mode_strap,
  input  wire logic                  width_select_strap,
  input  wire logic                  multiplexed_bus,
  input  wire logic                  single_strobe_style,
  input  wire logic                  hold_state,
  input  wire logic                  req_valid,
  input  wire logic                  req_write,
  input  wire logic                  req_word,
  input  wire logic [EBI_ADDR_W-1:0] req_addr,
  input  wire logic [1:0]            req_area,
  input  wire logic [EBI_DATA_W-1:0] req_wdata,
  output logic                       req_ready,
  output logic                       rsp_valid,
  output logic [EBI_DATA_W-1:0]      rsp_rdata,
  output logic                       microprocessor_mode,
  output logic                       bus_is_8bit,
  output logic [EBI_ADDR_W-1:0]      ext_addr_out,
  input  wire logic [EBI_DATA_W-1:0] ext_data_in,
  output logic [EBI_DATA_W-1:0]      ext_data_out,
  output logic [1:0]                 ext_data_oe,
  output logic [EBI_AREAS-1:0]       area_select_n,
  output logic                       read_strobe_n,
  output logic                       low_lane_write_strobe_n,
  output logic                       high_lane_write_strobe_n,
  output logic                       addr_latch_strobe,
  input  wire logic                  wait_request_n,
  output logic                       bus_grant_ack_n
);
  ebi_state_type                  state_r, state_nxt;
  logic [3:0]                     cnt_r;
  logic                           started_r;
  logic                           wr_r, word_r, mux_r, b8_r;
  logic [EBI_ADDR_W-1:0]          addr_r;
  logic [1:0]                     area_r;
  logic [EBI_DATA_W-1:0]          wdata_r;

  // Lane split and select decode assume two byte lanes, four areas
  if (EBI_DATA_W != 2 * EBI_LANE_W || EBI_AREAS != 4) begin : g_bad_cfg
    $error("ebi_core: unsupported data width or area count");
  end

  // Straps taken at the first clock after reset release [R3] [R1]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      started_r           <= 1'b0;
      microprocessor_mode <= 1'b0;
      bus_is_8bit         <= 1'b0;
    end else if (!started_r) begin
      started_r           <= 1'b1;
      microprocessor_mode <= (processor_mode_strap != EBI_MODE_SINGLE); // [R3]
      bus_is_8bit         <= (width_select_strap != EBI_WIDTH16); // [R1]
    end
  end

  // Decode of the current access
  wire        take      = (state_r == EBI_IDLE) && req_valid && started_r
                          && !hold_state;
  wire        cnt_done  = (cnt_r == 4'h0);
  wire        odd       = addr_r[0];
  wire        hi_lane   = !b8_r && (word_r || odd); // [R4]
  wire        lo_lane   = b8_r || word_r || !odd;
  // Multiplexed address: bits 0-7 on 8-bit, bits 1-8 on 16-bit [R6] [R7]
  wire [7:0]  mux_addr  = b8_r ? addr_r[7:0] : addr_r[8:1];
  // Wait sampled every edge; strobe ends only once high [R14] [R19]
  wire        strobe_end = cnt_done && wait_request_n;
  // Odd byte on a 16-bit separate bus travels on the high lane
  wire [EBI_DATA_W-1:0] rd_sel =
    (b8_r || (!word_r && !odd)) ? {8'h00, ext_data_in[7:0]} :
    (!word_r)                   ? {8'h00, ext_data_in[15:8]} :
                                  ext_data_in;

  // Sequencer
  // DONE gives one idle cycle so ready never overlaps the answer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      EBI_IDLE:   if (take) state_nxt = EBI_ADDR;
      EBI_ADDR:   if (cnt_done) state_nxt = EBI_STROBE;
      EBI_STROBE: if (strobe_end) state_nxt = EBI_DONE;
      EBI_DONE:   state_nxt = EBI_IDLE;
    endcase
  end

  // State, counters and captured request [R17]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= EBI_IDLE;
      cnt_r   <= 4'h0;
      wr_r    <= 1'b0;
      word_r  <= 1'b0;
      mux_r   <= 1'b0;
      b8_r    <= 1'b0;
      addr_r  <= '0;
      area_r  <= 2'h0;
      wdata_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (take) begin
        wr_r    <= req_write;
        word_r  <= req_word && !bus_is_8bit;
        mux_r   <= multiplexed_bus;
        b8_r    <= bus_is_8bit;
        addr_r  <= req_addr;
        area_r  <= req_area;
        wdata_r <= req_wdata;
        cnt_r   <= EBI_ADDR_CYC - 4'h1;
      end else if (state_r == EBI_ADDR && cnt_done) begin
        cnt_r   <= EBI_STB_CYC - 4'h1;
      end else if (!cnt_done) begin
        cnt_r   <= cnt_r - 4'h1;
      end
    end
  end

  // Registered pin outputs; read and write strobes and selects idle high, latch strobe idles low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ext_addr_out             <= '0;
      ext_data_out             <= '0;
      ext_data_oe              <= 2'b00;
      area_select_n            <= '1;
      read_strobe_n            <= 1'b1;
      low_lane_write_strobe_n  <= 1'b1;
      high_lane_write_strobe_n <= 1'b1;
      addr_latch_strobe        <= 1'b0;
      bus_grant_ack_n          <= 1'b1;
      req_ready                <= 1'b0;
      rsp_valid                <= 1'b0;
      rsp_rdata                <= '0;
    end else begin
      bus_grant_ack_n <= !(hold_state && state_nxt == EBI_IDLE); // [R15]
      req_ready       <= (state_nxt == EBI_IDLE) && started_r && !hold_state;
      rsp_valid       <= (state_r == EBI_STROBE) && strobe_end;
      if ((state_r == EBI_STROBE) && strobe_end && !wr_r)
        rsp_rdata <= rd_sel; // [R10]
      unique case (state_nxt)
        EBI_ADDR: begin
          ext_addr_out      <= addr_r_or_req();
          area_select_n     <= ~(4'h1 << area_sel_nxt()); // [R8]
          addr_latch_strobe <= multiplexed_bus; // [R13] [R18]
          ext_data_out      <= multiplexed_bus ?
                               {8'h00, mux_next_addr()} : '0;
          ext_data_oe       <= multiplexed_bus ? 2'b01 : 2'b00;
        end
        EBI_STROBE: begin
          ext_addr_out      <= addr_r; // [R5]
          addr_latch_strobe <= 1'b0; // [R18]
          read_strobe_n     <= wr_r; // [R10]
          if (single_strobe_style || b8_r) begin // [R11] [R12]
            low_lane_write_strobe_n  <= !wr_r;
            high_lane_write_strobe_n <= !hi_lane; // Byte-high enable
          end else begin
            low_lane_write_strobe_n  <= !(wr_r && lo_lane); // [R9]
            high_lane_write_strobe_n <= !(wr_r && hi_lane); // [R9]
          end
          // Multiplexed bus carries data 0-7 on low lane [R6] [R7]
          ext_data_out <= (!word_r && odd && !b8_r && !mux_r) ?
                          {wdata_r[7:0], 8'h00} : wdata_r;
          ext_data_oe  <= wr_r ? {hi_lane && !mux_r, 1'b1} : 2'b00; // [R4]
        end
        default: begin
          area_select_n            <= '1;
          read_strobe_n            <= 1'b1;
          low_lane_write_strobe_n  <= 1'b1;
          high_lane_write_strobe_n <= 1'b1;
          addr_latch_strobe        <= 1'b0;
          ext_data_oe              <= 2'b00;
        end
      endcase
    end
  end

  // A request taken this edge must reach the pins at once, so the
  // address phase reads the request ports directly rather than the
  // captured copy, which only lands on the same edge.
  // Address source: new request while idle, else captured one
  function automatic logic [EBI_ADDR_W-1:0] addr_r_or_req();
    return take ? req_addr : addr_r;
  endfunction
  function automatic logic [1:0] area_sel_nxt();
    return take ? req_area : area_r;
  endfunction
  function automatic logic [7:0] mux_next_addr();
    return take ? (bus_is_8bit ? req_addr[7:0] : req_addr[8:1]) : mux_addr;
  endfunction

  // Limitation: a multiplexed word leaves the upper lane undriven;
  // only one lane of eight lines carries data there.
  // Hold is honoured only between accesses, never inside a cycle
  // Bus request input has no function, so no port exists for it [R16]
  // Width strap held low in single-chip is the board's duty [R2]
endmodule

// *** ebi_pkg.sv ***
// Package for the external bus interface: bus modes, states, constants.
// Assumes one 25 MHz system clock and a synchronous active-high reset.
package ebi_pkg;
  localparam int          EBI_ADDR_W     = 20;
  localparam int          EBI_DATA_W     = 16;
  localparam int          EBI_AREAS      = 4;
  localparam int          EBI_LANE_W     = 8;
  // Strap levels
  localparam logic        EBI_WIDTH16    = 1'b0;
  localparam logic        EBI_MODE_SINGLE = 1'b0;
  // Bus cycle timing in system clocks (address phase, least strobe)
  localparam logic [3:0]  EBI_ADDR_CYC   = 4'h1;
  localparam logic [3:0]  EBI_STB_CYC    = 4'h1;
  typedef enum logic [2:0] {
    EBI_IDLE,
    EBI_ADDR,
    EBI_STROBE,
    EBI_DONE
  } ebi_state_type;
endpackage

// *** ebi_mem_model.sv ***
// Far-side memory: a byte store that can hold the wait line low.
// Takes the address from the address outputs, the width from the strap.
module ebi_mem_model
  import ebi_pkg::*;
(
  input  wire logic clk_sys, width_select_strap, single_strobe_style,
  input  wire logic read_strobe_n, low_lane_write_strobe_n,
  input  wire logic high_lane_write_strobe_n,
  input  wire logic [3:0]            stall,
  input  wire logic [EBI_ADDR_W-1:0] ext_addr_out,
  input  wire logic [EBI_DATA_W-1:0] ext_data_out,
  output logic      [EBI_DATA_W-1:0] ext_data_in,
  output logic                       wait_request_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [256];
  logic [15:0] idle_r = 16'h5a5a;
  logic [3:0]  cnt_r  = 4'h0;
  logic [7:0]  a, ev;
  logic        sgl, act, lo, hi;
  // Lane enables; the 8-bit bus always runs in single strobe style
  assign a   = ext_addr_out[7:0];
  assign ev  = {a[7:1], 1'b0};
  assign sgl = single_strobe_style | width_select_strap;
  assign act = !(read_strobe_n & low_lane_write_strobe_n);
  assign lo  = !low_lane_write_strobe_n & (!sgl | width_select_strap | !a[0]);
  assign hi  = !high_lane_write_strobe_n & (!sgl | !low_lane_write_strobe_n);
  // Wait held low for the first stall cycles of each read or low-lane write strobe
  assign wait_request_n = !(act && cnt_r != 4'h0);
  // Released lanes toggle, so stale data never passes as read data
  assign ext_data_in = read_strobe_n ? idle_r : width_select_strap ?
    {idle_r[15:8], mem[a]} : {mem[ev | 8'h1], mem[ev]};
  always @(posedge clk_sys) begin
    idle_r <= ~ext_data_in;
    cnt_r <= act ? cnt_r - {3'h0, cnt_r != 4'h0} : stall;
    if (lo && width_select_strap) mem[a] <= ext_data_out[7:0];
    if (lo && !width_select_strap) mem[ev] <= ext_data_out[7:0];
    if (hi && !width_select_strap) mem[ev | 8'h1] <= ext_data_out[15:8];
  end
endmodule

// *** ebi_core_properties.sv ***
// Checker: cycle relations of requests, strobes and selects.
// Bound onto ebi_core; one clock, synchronous active-high reset.
module ebi_core_properties
  import ebi_pkg::*;
(
  input wire logic clk_sys, rst, req_valid, req_ready, rsp_valid,
  input wire logic single_strobe_style, bus_is_8bit, wait_request_n,
  input wire logic read_strobe_n, low_lane_write_strobe_n,
  input wire logic high_lane_write_strobe_n, addr_latch_strobe,
  input wire logic                  bus_grant_ack_n,
  input wire logic [1:0]            ext_data_oe,
  input wire logic [EBI_AREAS-1:0]  area_select_n,
  input wire logic [EBI_ADDR_W-1:0] ext_addr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_take; req_valid && req_ready |=> !req_ready ##[2:40] rsp_valid;
  endproperty
  a_take: assert property (p_take) else $error("no answer");
  property p_rsp; rsp_valid |-> $past(wait_request_n) ##1 !rsp_valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("early end");
  property p_wait; !wait_request_n && !read_strobe_n |=> !read_strobe_n;
  endproperty
  a_wait: assert property (p_wait) else $error("no stretch");
  property p_ale; addr_latch_strobe |=> !addr_latch_strobe &&
    !(read_strobe_n && low_lane_write_strobe_n && high_lane_write_strobe_n);
  endproperty
  a_ale: assert property (p_ale) else $error("latch phase");
  property p_sel; !read_strobe_n |-> $onehot(~area_select_n); endproperty
  a_sel: assert property (p_sel) else $error("area select");
  property p_rd; !read_strobe_n |-> ext_data_oe == 2'h0; endproperty
  a_rd: assert property (p_rd) else $error("drive in read");
  property p_lane; !bus_is_8bit && !single_strobe_style &&
    (low_lane_write_strobe_n != high_lane_write_strobe_n)
    |-> ext_addr_out[0] == low_lane_write_strobe_n; endproperty
  a_lane: assert property (p_lane) else $error("lane strobe");
  property p_hold; !bus_grant_ack_n |-> !req_ready && read_strobe_n;
  endproperty
  a_hold: assert property (p_hold) else $error("hold access");
  c_wait: cover property (!wait_request_n && !read_strobe_n);
  c_ale: cover property (addr_latch_strobe);
  c_hold: cover property (!bus_grant_ack_n);
endmodule
bind ebi_core ebi_core_properties u_props (.*);

// *** tb_ebi_core.sv ***
// Bench for the external bus interface with a memory on the far side.
// Inputs change on the falling edge of the 25 MHz clock.
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: value mismatch", $time); end end
module tb_ebi_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst = 1, processor_mode_strap = 1, hold_state = 0;
  logic width_select_strap = 0, multiplexed_bus = 0, req_valid = 0;
  logic single_strobe_style = 0, req_write = 0, req_word = 0;
  logic req_ready, rsp_valid, microprocessor_mode, bus_is_8bit;
  logic read_strobe_n, low_lane_write_strobe_n, high_lane_write_strobe_n;
  logic addr_latch_strobe, wait_request_n, bus_grant_ack_n;
  logic [19:0] req_addr = 20'h0, ext_addr_out;
  logic [15:0] req_wdata = 16'h0, rsp_rdata, ext_data_in, ext_data_out;
  logic [1:0]  req_area = 2'h0, ext_data_oe;
  logic [3:0]  area_select_n, stall = 4'h0;
  int          n_fail = 0, comparisons = 0, cyc = 0;
  ebi_core      dut (.*);
  ebi_mem_model u_mem (.*);
  initial forever #20 clk_sys = ~clk_sys;
  // Run needs well under 1000 cycles; a hang ends here
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    $display("mismatches %0d, comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Straps stay fixed while out of reset; single-chip ties width low
  task automatic rst_to(input logic pm, b8);
    @(negedge clk_sys) rst = 1;
    processor_mode_strap = pm;
    width_select_strap = b8;
    repeat (8) @(negedge clk_sys);
    rst = 0;
    repeat (2) @(negedge clk_sys);
    `CHK(microprocessor_mode, pm)
    `CHK({bus_is_8bit, area_select_n}, {b8, 4'hf})
  endtask
  // One access; checks phase outputs, latency and read data
  task automatic acc(input logic w, wd, input logic [19:0] a,
    input logic [1:0] ar, input logic [15:0] d, e, input logic [3:0] st);
    int n;
    n = 1;
    while (req_ready !== 1'b1) @(negedge clk_sys);
    {stall, req_write, req_word, req_addr, req_area} = {st, w, wd, a, ar};
    req_wdata = d;
    req_valid = 1;
    @(negedge clk_sys) req_valid = 0;
    // Address phase stands one cycle; latch strobe is high in it only on a multiplexed bus
    `CHK({ext_addr_out, area_select_n}, {a, ~(4'h1 << ar)})
    `CHK(addr_latch_strobe, multiplexed_bus)
    if (multiplexed_bus)
      `CHK(ext_data_out[7:0], bus_is_8bit ? a[7:0] : a[8:1])
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(n, 3 + st)
    if (!w) `CHK(rsp_rdata & (wd ? 16'hffff : 16'h00ff), e)
  endtask
  task automatic t_lanes;
    rst_to(1, 0);
    acc(1, 1, 20'h00010, 0, 16'ha55a, 0, 0);
    acc(1, 0, 20'h00013, 1, 16'h3c3c, 0, 0);
    acc(1, 0, 20'h00012, 2, 16'hc3c3, 0, 0);
    acc(0, 1, 20'h00012, 3, 0, 16'h3cc3, 0);
    acc(0, 1, 20'h00010, 0, 0, 16'ha55a, 3);
  endtask
  task automatic t_mux16;
    multiplexed_bus = 1;
    single_strobe_style = 1;
    acc(1, 1, 20'h00120, 1, 16'hbeef, 0, 0);
    acc(0, 1, 20'h00120, 1, 0, 16'hbeef, 1);
  endtask
  task automatic t_bus8;
    rst_to(1, 1);
    acc(1, 0, 20'h00045, 2, 16'h0077, 0, 0);
    acc(0, 0, 20'h00045, 2, 0, 16'h0077, 2);
  endtask
  task automatic t_hold;
    hold_state = 1;
    repeat (4) @(negedge clk_sys);
    `CHK({bus_grant_ack_n, req_ready}, 2'b00)
    hold_state = 0;
    repeat (3) @(negedge clk_sys);
    `CHK({bus_grant_ack_n, req_ready}, 2'b11)
  endtask
  initial begin
    t_lanes;
    t_mux16;
    t_bus8;
    t_hold;
    rst_to(0, 0);
    give_verdict;
  end
endmodule
